//--- src/acfc_frame_ctrl.sv
// Purpose: converter slot sequencing, result storage and chopper control
// Assumes: APB slave on pclk; slot table and converter outside
// Notes: one frame-clock tick is one pclk pulse from the pin sampler
// How it works
// - Conversion length and resolution follow clock selects and depth.
// - Conversions start only from the slot sequencer.
// - Results go to fixed words by signal number; temp 0x0A, battery 0x0B.
// - Results are LSB justified then shifted left eight bits.
// - Chopper mode field sits at bits 5:4 of register 0x2002.
// - After the last slot one extra frame-clock cycle is inserted.
// - Polarity is updated from the mode at start of that cycle.
// - Frame sync is high for the whole inserted cycle.
// - Frame sync rising edge launches the compute engine pass.
// - Positive mode holds polarity and chopper clock low.
// - Reverse mode also holds both low; static high awaits confirmation.
// - Mode 00 pulses the chopper clock every frame and forces last frame alternate.
// - Mode 00 skips the toggle before the forced alternate frame.
// - Frames per accumulation interval are always even.
// - Mode 11 forces no alternate frame and always toggles.
// - High polarity swaps the reference amplifier inputs.
// - Battery converts in alternate frames only while enabled.
// - Battery result lands in word 0x0B in each alternate frame while enabled.
// - Without main power the battery enable reads as zero.
// - Alternate request edge gives exactly one alternate frame.
// - Each slot lasts one to three frame-clock cycles.
// - A frame runs from its first slot through the slot count.
`timescale 1ns/1ps
`default_nettype none
module acfc_frame_ctrl
	import acfc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ACFC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frame_clock,
	input wire logic power_good_pin,
	input wire logic [3:0] slot_signal,
	input wire logic conv_done,
	input wire logic [23:0] conv_data,
	output logic conv_start,
	output logic [9:0] conv_cycles,
	output logic [4:0] conv_bits,
	output logic [3:0] slot_index,
	output logic alt_frame,
	output logic ram_we,
	output logic [ACFC_RAM_AW-1:0] ram_addr,
	output logic [31:0] ram_wdata,
	output logic frame_sync,
	output logic chopper_polarity,
	output logic chopper_clock,
	output logic amp_input_swap,
	output logic battery_measure_enable
);
	typedef enum logic [1:0] {
		ACFC_ST_WAIT,
		ACFC_ST_SLOT,
		ACFC_ST_SETTLE
	} acfc_state_t;

	acfc_sync_if sync_if ();

	acfc_pin_sync u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.frame_clock(frame_clock),
		.power_good_pin(power_good_pin),
		.sync(sync_if.src)
	);

	logic [9:0] ctl_q;
	logic [5:0] frames_q;
	logic [7:0] chop_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic alt_prev_q;
	logic alt_pend_q;
	acfc_state_t state_q;
	logic [3:0] slot_q;
	logic [1:0] cyc_q;
	logic [5:0] frame_idx_q;
	logic alt_frame_q;
	logic conv_start_q;
	logic [9:0] conv_cycles_q;
	logic [4:0] conv_bits_q;
	logic frame_sync_q;
	logic polarity_q;
	logic chopper_clock_q;
	logic swap_q;
	logic bme_q;
	logic ram_we_q;
	logic [ACFC_RAM_AW-1:0] ram_addr_q;
	logic [31:0] ram_wdata_q;

	// Bus decode
	wire [13:0] idx = paddr[ACFC_ADDR_W-1:2];
	wire hit_ctl = (idx == ACFC_IDX_CONTROL);
	wire hit_frm = (idx == ACFC_IDX_FRAMES);
	wire hit_chp = (idx == ACFC_IDX_CHOPPER);
	wire hit_sts = (idx == ACFC_IDX_STATUS);
	wire hit_any = hit_ctl | hit_frm | hit_chp | hit_sts;
	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;

	// Field views
	wire sel_lo = ctl_q[ACFC_CTL_SEL_LO];
	wire sel_hi = ctl_q[ACFC_CTL_SEL_HI];
	wire [1:0] depth = ctl_q[ACFC_CTL_DEPTH_LSB +: 2];
	wire [3:0] count_raw = ctl_q[ACFC_CTL_COUNT_LSB +: 4];
	wire alt_req = ctl_q[ACFC_CTL_ALT];
	wire acfc_chop_t mode = acfc_chop_t'(chop_q[ACFC_CHOP_MODE_LSB +: 2]);

	// Modes that run the chopper clock
	function automatic logic acfc_chop_toggles(input acfc_chop_t m);
		case (m)
			ACFC_CHOP_TOGGLE_ALT: acfc_chop_toggles = 1'b1;
			ACFC_CHOP_TOGGLE: acfc_chop_toggles = 1'b1;
			default: acfc_chop_toggles = 1'b0;
		endcase
	endfunction

	// Effective battery enable
	wire bme_eff = ctl_q[ACFC_CTL_BME] & sync_if.power_good;

	// Slot and frame limits
	wire [1:0] slot_last_cyc = (depth == 2'h0) ? 2'h0 :
		(depth == 2'h1) ? 2'h1 : 2'h2;
	wire [3:0] slot_count = (count_raw == 4'h0) ? 4'h1 :
		(count_raw > ACFC_MAX_SLOTS) ? ACFC_MAX_SLOTS : count_raw;
	wire [5:0] frames_even = (frames_q[5:1] == 5'h00) ? ACFC_MIN_FRAMES :
		{frames_q[5:1], 1'b0};
	wire [5:0] frames_last = frames_even - 6'h01;
	wire [5:0] upcoming = (frame_idx_q >= frames_last) ? 6'h00 :
		frame_idx_q + 6'h01;
	wire next_is_last = (upcoming == frames_last);

	// Forced alternate frame in toggle-with-alternate mode
	wire force_alt = (mode == ACFC_CHOP_TOGGLE_ALT) & next_is_last;
	// mode 11 never forces, so force_alt stays low there

	// Polarity at the settling cycle
	wire skip_toggle = (mode == ACFC_CHOP_TOGGLE_ALT) & next_is_last;
	wire pol_next = ((mode == ACFC_CHOP_POSITIVE) |
		(mode == ACFC_CHOP_REVERSE)) ? 1'b0 :
		(skip_toggle ? polarity_q : ~polarity_q);
	wire toggling = acfc_chop_toggles(mode);

	// Sequencer events
	wire tick = sync_if.ck_rise;
	wire frame_start = tick & (state_q != ACFC_ST_SLOT);
	wire slot_end = tick & (state_q == ACFC_ST_SLOT) &
		(cyc_q == slot_last_cyc);
	// Ends the frame even if the count shrank mid-frame
	wire frame_end = slot_end & (slot_q >= slot_count - 4'h1);
	wire slot_next = slot_end & ~frame_end;
	wire alt_rise = alt_req & ~alt_prev_q;

	// Result placement
	wire [23:0] res_mask = 24'hFFFFFF >> (5'h18 - conv_bits_q);
	wire [31:0] res_word = {conv_data & res_mask, 8'h00};
	wire sig_main = (slot_signal <= ACFC_SIG_LAST_MAIN);
	wire sig_temp = (slot_signal == ACFC_SIG_TEMP);
	wire sig_batt = (slot_signal == ACFC_SIG_BATT);
	wire batt_ok = sig_batt & alt_frame_q & bme_q;
	wire store = conv_done & (sig_main | sig_temp | batt_ok);

	// Read data
	wire [31:0] status_word = {22'h000000, sync_if.power_good, alt_pend_q,
		frame_sync_q, alt_frame_q, polarity_q, bme_q, slot_q};
	wire [31:0] rd_word = hit_ctl ? {22'h000000, ctl_q} :
		hit_frm ? {26'h0000000, frames_q} :
		hit_chp ? {24'h000000, chop_q} :
		hit_sts ? status_word : 32'h00000000;

	// APB slave, answers in the cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~hit_any;
			if (setup) begin
				prdata_q <= rd_word;
			end
		end
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= ACFC_CONTROL_RST;
			frames_q <= ACFC_FRAMES_RST;
			chop_q <= ACFC_CHOPPER_RST;
		end else if (wr_en) begin
			if (hit_ctl) begin
				ctl_q <= pwdata[9:0];
			end
			if (hit_frm) begin
				frames_q <= pwdata[5:0];
			end
			if (hit_chp) begin
				chop_q <= pwdata[7:0];
			end
		end
	end

	// Alternate request edge, pending until a frame takes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alt_prev_q <= 1'b0;
			alt_pend_q <= 1'b0;
		end else begin
			alt_prev_q <= alt_req;
			if (alt_rise) begin
				alt_pend_q <= 1'b1;
			end else if (frame_start) begin
				alt_pend_q <= 1'b0;
			end
		end
	end

	// Frame and slot state machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ACFC_ST_WAIT;
			slot_q <= 4'h0;
			cyc_q <= 2'h0;
			frame_idx_q <= 6'h00;
			alt_frame_q <= 1'b0;
		end else begin
			case (state_q)
				ACFC_ST_WAIT, ACFC_ST_SETTLE: begin
					if (tick) begin
						state_q <= ACFC_ST_SLOT;
						slot_q <= 4'h0;
						cyc_q <= 2'h0;
						frame_idx_q <= upcoming;
						alt_frame_q <= alt_pend_q | force_alt;
					end
				end
				ACFC_ST_SLOT: begin
					if (frame_end) begin
						state_q <= ACFC_ST_SETTLE;
					end else if (slot_next) begin
						slot_q <= slot_q + 4'h1;
						cyc_q <= 2'h0;
					end else if (tick) begin
						cyc_q <= cyc_q + 2'h1;
					end
				end
				default: begin
					state_q <= ACFC_ST_WAIT;
				end
			endcase
		end
	end

	// Conversion launch and setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_start_q <= 1'b0;
			conv_cycles_q <= 10'h000;
			conv_bits_q <= 5'h00;
		end else begin
			conv_start_q <= frame_start | slot_next;
			if (frame_start | slot_next) begin
				conv_cycles_q <= acfc_fir_cycles(sel_hi, sel_lo, depth);
				conv_bits_q <= acfc_fir_bits(sel_hi, sel_lo, depth);
			end
		end
	end

	// Settling cycle: sync pulse and chopper update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_sync_q <= 1'b0;
			polarity_q <= 1'b0;
			chopper_clock_q <= 1'b0;
			swap_q <= 1'b0;
		end else begin
			if (frame_end) begin
				frame_sync_q <= 1'b1;
				polarity_q <= pol_next;
				swap_q <= pol_next;
				chopper_clock_q <= toggling;
			end else if (frame_start) begin
				frame_sync_q <= 1'b0;
				chopper_clock_q <= 1'b0;
			end else if (!toggling) begin
				polarity_q <= 1'b0;
				swap_q <= 1'b0;
				chopper_clock_q <= 1'b0;
			end
		end
	end

	// Result store into the shared data RAM
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ram_we_q <= 1'b0;
			ram_addr_q <= '0;
			ram_wdata_q <= 32'h00000000;
			bme_q <= 1'b0;
		end else begin
			bme_q <= bme_eff;
			ram_we_q <= store;
			if (store) begin
				ram_addr_q <= {6'h00, slot_signal};
				ram_wdata_q <= res_word;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign conv_start = conv_start_q;
	assign conv_cycles = conv_cycles_q;
	assign conv_bits = conv_bits_q;
	assign slot_index = slot_q;
	assign alt_frame = alt_frame_q;
	assign ram_we = ram_we_q;
	assign ram_addr = ram_addr_q;
	assign ram_wdata = ram_wdata_q;
	assign frame_sync = frame_sync_q;
	assign chopper_polarity = polarity_q;
	assign chopper_clock = chopper_clock_q;
	assign amp_input_swap = swap_q;
	assign battery_measure_enable = bme_q;
endmodule
`default_nettype wire

//--- src/acfc_pin_sync.sv
// Purpose: two-stage sampling of frame clock and power-good pins
// Assumes: frame clock far slower than pclk
// Notes: edge detect reads only the second stage onward
`timescale 1ns/1ps
`default_nettype none
module acfc_pin_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic frame_clock,
	input wire logic power_good_pin,
	acfc_sync_if.src sync
);
	logic [2:0] ck_q;
	logic [1:0] pg_q;
	logic rise_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_q <= 3'h0;
			pg_q <= 2'h0;
			rise_q <= 1'b0;
		end else begin
			ck_q <= {ck_q[1:0], frame_clock};
			pg_q <= {pg_q[0], power_good_pin};
			rise_q <= ck_q[1] & ~ck_q[2];
		end
	end

	assign sync.ck_rise = rise_q;
	assign sync.power_good = pg_q[1];
endmodule
`default_nettype wire

//--- src/acfc_pkg.sv
// Purpose: shared constants and decoders for the converter frame control
// Assumes: APB word registers at four times their index
// Notes: frame clock arrives as a pin and is sampled on pclk
package acfc_pkg;

	localparam int unsigned ACFC_ADDR_W = 16;
	localparam int unsigned ACFC_RAM_AW = 10;

	// Register indices, byte address is four times the index
	localparam logic [13:0] ACFC_IDX_CONTROL = 14'h2000;
	localparam logic [13:0] ACFC_IDX_FRAMES = 14'h2001;
	localparam logic [13:0] ACFC_IDX_CHOPPER = 14'h2002;
	localparam logic [13:0] ACFC_IDX_STATUS = 14'h2003;

	// Control and chopper register fields
	localparam int unsigned ACFC_CTL_SEL_LO = 0;
	localparam int unsigned ACFC_CTL_SEL_HI = 1;
	localparam int unsigned ACFC_CTL_DEPTH_LSB = 2;
	localparam int unsigned ACFC_CTL_COUNT_LSB = 4;
	localparam int unsigned ACFC_CTL_ALT = 8;
	localparam int unsigned ACFC_CTL_BME = 9;
	localparam int unsigned ACFC_CHOP_MODE_LSB = 4;

	// Reset values
	localparam logic [9:0] ACFC_CONTROL_RST = 10'h070;
	localparam logic [5:0] ACFC_FRAMES_RST = 6'h02;
	localparam logic [7:0] ACFC_CHOPPER_RST = 8'h00;

	// Slot and signal limits
	localparam logic [3:0] ACFC_MAX_SLOTS = 4'hA;
	localparam logic [3:0] ACFC_SIG_LAST_MAIN = 4'h6;
	localparam logic [3:0] ACFC_SIG_TEMP = 4'hA;
	localparam logic [3:0] ACFC_SIG_BATT = 4'hB;
	localparam logic [5:0] ACFC_MIN_FRAMES = 6'h02;
	localparam int unsigned ACFC_RESULT_SHIFT = 8;

	typedef enum logic [1:0] {
		ACFC_CHOP_TOGGLE_ALT = 2'b00,
		ACFC_CHOP_POSITIVE = 2'b01,
		ACFC_CHOP_REVERSE = 2'b10,
		ACFC_CHOP_TOGGLE = 2'b11
	} acfc_chop_t;

	// Engine cycles per conversion
	function automatic logic [9:0] acfc_fir_cycles(input logic hi,
		input logic lo, input logic [1:0] depth);
		logic fast;
		fast = ~hi & lo;
		case (depth)
			2'h0: acfc_fir_cycles = fast ? 10'h0BA : 10'h08A;
			2'h1: acfc_fir_cycles = fast ? 10'h180 : 10'h120;
			default: acfc_fir_cycles = fast ? 10'h24C : 10'h180;
		endcase
	endfunction

	// Result width in bits
	function automatic logic [4:0] acfc_fir_bits(input logic hi,
		input logic lo, input logic [1:0] depth);
		logic fast;
		fast = ~hi & lo;
		case (depth)
			2'h0: acfc_fir_bits = fast ? 5'h13 : 5'h12;
			2'h1: acfc_fir_bits = fast ? 5'h16 : 5'h15;
			default: acfc_fir_bits = fast ? 5'h18 : 5'h16;
		endcase
	endfunction

endpackage

//--- src/acfc_sync_if.sv
// Purpose: carries synchronised pin events to the frame controller
// Assumes: single pclk domain
// Notes: src side drives, dst side reads
`timescale 1ns/1ps
`default_nettype none
interface acfc_sync_if;
	logic ck_rise;
	logic power_good;
	modport src (output ck_rise, output power_good);
	modport dst (input ck_rise, input power_good);
endinterface
`default_nettype wire

//--- tb/acfc_conv_model.sv
// Purpose: converter, slot table and shared RAM model
// Assumes: slot lasts longer than the conversion delay
// Notes: alternate slots 0 and 2 carry temperature and battery
`timescale 1ns/1ps
`default_nettype none
module acfc_conv_model #(
	parameter logic [2:0] DLY = 3'h4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic conv_start,
	input wire logic [3:0] slot_index,
	input wire logic alt_frame,
	input wire logic frame_sync,
	input wire logic ram_we,
	input wire logic [9:0] ram_addr,
	input wire logic [31:0] ram_wdata,
	output logic [3:0] slot_signal,
	output logic conv_done,
	output logic [23:0] conv_data
);
	logic [31:0] mem [0:15];
	logic [2:0] wait_q;
	logic sync_q;
	int passes;
	assign slot_signal = !alt_frame ? slot_index :
		slot_index == 4'h0 ? 4'hA : slot_index == 4'h2 ? 4'hB : slot_index;
	assign conv_done = wait_q == 3'h1;
	// Idle data bus shows the inverse pattern
	assign conv_data = conv_done ? {20'hC35A9, slot_signal} :
		~{20'hC35A9, slot_signal};
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 3'h0;
			sync_q <= 1'b0;
			passes <= 0;
		end else begin
			if (conv_start)
				wait_q <= DLY;
			else if (wait_q != 3'h0)
				wait_q <= wait_q - 3'h1;
			sync_q <= frame_sync;
			if (frame_sync && !sync_q)
				passes <= passes + 1;
			if (ram_we)
				mem[ram_addr[3:0]] <= ram_wdata;
		end
	end
endmodule
`default_nettype wire

//--- tb/acfc_frame_ctrl_props.sv
// Purpose: port checks for the frame controller
// Assumes: single pclk domain
// Notes: bound to every frame controller
`timescale 1ns/1ps
`default_nettype none
module acfc_props
	import acfc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic power_good_pin,
	input wire logic [3:0] slot_signal,
	input wire logic conv_done,
	input wire logic [23:0] conv_data,
	input wire logic conv_start,
	input wire logic [9:0] conv_cycles,
	input wire logic [4:0] conv_bits,
	input wire logic [3:0] slot_index,
	input wire logic alt_frame,
	input wire logic ram_we,
	input wire logic [ACFC_RAM_AW-1:0] ram_addr,
	input wire logic [31:0] ram_wdata,
	input wire logic frame_sync,
	input wire logic chopper_polarity,
	input wire logic chopper_clock,
	input wire logic amp_input_swap,
	input wire logic battery_measure_enable
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire [23:0] mask = (24'h1 << conv_bits) - 24'h1;
	wire pair_ok = {conv_cycles, conv_bits} inside {{10'h08A, 5'h12},
		{10'h120, 5'h15}, {10'h180, 5'h16}, {10'h0BA, 5'h13},
		{10'h24C, 5'h18}};
	a_pair_legal: assert property (ram_we |-> pair_ok)
		else $error("cycles and bits disagree");
	a_start_single: assert property (conv_start |=> !conv_start)
		else $error("start pulse too long");
	a_store_addr: assert property (ram_we |-> $past(conv_done) &&
		ram_addr == {6'h00, $past(slot_signal)})
		else $error("result stored at wrong word");
	a_store_data: assert property (ram_we |->
		ram_wdata == {$past(conv_data) & mask, 8'h00})
		else $error("result word misaligned");
	a_settle_idle: assert property (frame_sync |-> !conv_start)
		else $error("conversion during settle");
	a_chop_clock: assert property (chopper_clock |-> frame_sync)
		else $error("chopper clock outside settle");
	a_frame_restart: assert property ($fell(frame_sync) |->
		slot_index == 4'h0 && conv_start)
		else $error("frame did not restart at slot 0");
	a_swap_mirror: assert property (amp_input_swap == chopper_polarity)
		else $error("swap differs from polarity");
	a_batt_gate: assert property (ram_we && ram_addr == 10'h00B |->
		alt_frame && battery_measure_enable)
		else $error("battery stored outside alternate frame");
	a_bme_power: assert property ((!power_good_pin) [*5] |->
		!battery_measure_enable)
		else $error("battery enable without power");
	a_alt_whole: assert property ($rose(alt_frame) |->
		slot_index == 4'h0 && !frame_sync)
		else $error("alternate frame began mid frame");
endmodule
bind acfc_frame_ctrl acfc_props u_props (.*);
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench for the frame controller
// Assumes: frame clock sped up to 40 pclk periods
// Notes: register indices as the package gives them
`timescale 1ns/1ps
`default_nettype none
module tb;
	import acfc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, ram_wdata, rv;
	logic frame_clock, power_good_pin, conv_done, conv_start, alt_frame;
	logic ram_we, frame_sync, chopper_polarity, chopper_clock;
	logic amp_input_swap, battery_measure_enable;
	logic [3:0] slot_signal, slot_index;
	logic [23:0] conv_data;
	logic [9:0] conv_cycles, ram_addr;
	logic [4:0] conv_bits;
	int bad_count, samples_checked, cyc;
	logic [9:0] cyc_tab [6] = '{10'h08A, 10'h120, 10'h180, 10'h0BA,
		10'h180, 10'h24C};
	logic [4:0] bit_tab [6] = '{5'h12, 5'h15, 5'h16, 5'h13, 5'h16, 5'h18};
	acfc_frame_ctrl uut (.*);
	acfc_conv_model u_far (.*);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		frame_clock = 1'b0;
		forever #100 frame_clock = ~frame_clock;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish;
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [13:0] i,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [31:0] ew(input logic [3:0] s, logic [4:0] b);
		return {{20'hC35A9, s} & ((24'h1 << b) - 24'h1), 8'h00};
	endfunction
	task automatic until_sync(input int n);
		repeat (n) begin
			do @(posedge pclk); while (frame_sync !== 1'b1);
			do @(posedge pclk); while (frame_sync !== 1'b0);
		end
	endtask
	task automatic wait_slot(input logic [3:0] n);
		do @(posedge pclk); while (!(conv_start === 1'b1 && slot_index === n));
	endtask
	task automatic t_regs;
		apb(1'b0, ACFC_IDX_CHOPPER, 32'h0);
		check("chop rst", rv, 32'h0);
		apb(1'b1, ACFC_IDX_CHOPPER, 32'hFF);
		apb(1'b0, ACFC_IDX_CHOPPER, 32'h0);
		check("chop rw", rv, 32'hFF);
		apb(1'b0, 14'h2004, 32'h0);
		check("unmapped", re, 32'h1);
	endtask
	task automatic t_res;
		int k, t0;
		for (int s = 0; s < 4; s++) begin
			for (int d = 0; d < 3; d++) begin
				k = (s == 1) ? d + 3 : d;
				apb(1'b1, ACFC_IDX_CONTROL, 32'h20 | (d << 2) | s);
				until_sync(1);
				u_far.mem[0] = 32'h0;
				wait_slot(4'h0);
				t0 = cyc;
				wait_slot(4'h1);
				check("cycles", conv_cycles, cyc_tab[k]);
				check("bits", conv_bits, bit_tab[k]);
				check("slot len", cyc - t0, 40 * (d + 1));
				check("word0", u_far.mem[0], ew(4'h0, 5'(bit_tab[k])));
			end
		end
	endtask
	task automatic alt_run(input logic pg);
		power_good_pin <= pg;
		u_far.mem[10] = 32'h0;
		u_far.mem[11] = 32'h0;
		apb(1'b1, ACFC_IDX_CONTROL, 32'h230);
		apb(1'b1, ACFC_IDX_CONTROL, 32'h330);
		repeat (3) if (alt_frame !== 1'b1) until_sync(1);
		check("bme", battery_measure_enable, pg);
		until_sync(1);
		check("one alt", alt_frame, 32'h0);
		check("temp", u_far.mem[10], ew(4'hA, 5'h12));
		check("batt", u_far.mem[11], pg ? ew(4'hB, 5'h12) : 0);
	endtask
	task automatic t_chop;
		logic a[8], p[8];
		int n;
		n = u_far.passes;
		until_sync(1);
		p[0] = chopper_polarity;
		for (int i = 1; i < 5; i++) begin
			until_sync(1);
			check("tog11", chopper_polarity, p[0] ^ i[0]);
			check("swap", amp_input_swap, p[0] ^ i[0]);
			check("noalt", alt_frame, 32'h0);
		end
		check("passes", u_far.passes - n, 5);
		apb(1'b1, ACFC_IDX_CHOPPER, 32'h0);
		apb(1'b1, ACFC_IDX_FRAMES, 32'h3);
		for (int i = 0; i < 8; i++) begin
			until_sync(1);
			a[i] = alt_frame;
			p[i] = chopper_polarity;
		end
		for (int i = 3; i < 8; i++) begin
			check("altcad", a[i], !a[i-1]);
			check("pol00", p[i], a[i] ? p[i-1] : !p[i-1]);
		end
		for (int m = 1; m < 3; m++) begin
			apb(1'b1, ACFC_IDX_CHOPPER, m << 4);
			until_sync(1);
			do @(posedge pclk); while (frame_sync !== 1'b1);
			n = cyc;
			check("ckclk", chopper_clock, 32'h0);
			check("pol", chopper_polarity, 32'h0);
			do @(posedge pclk); while (frame_sync !== 1'b0);
			check("settle", cyc - n, 40);
		end
	endtask
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		power_good_pin = 1'b1;
		{bad_count, samples_checked, cyc} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_res();
		alt_run(1'b1);
		alt_run(1'b0);
		t_chop();
		tally_and_finish();
	end
endmodule
`default_nettype wire
